// ### ipg_pkg.sv
// package for the idle / geometry command interpreter
// assumes a single 50 MHz clock domain
package ipg_pkg;

  // command codes (both opcode variants of idle and idle immediate, one of geometry)
  localparam logic [7:0] CMD_IDLE_A = 8'he3;
  localparam logic [7:0] CMD_IDLE_B = 8'h97;
  localparam logic [7:0] CMD_IDLE_IMM_A = 8'he1;
  localparam logic [7:0] CMD_IDLE_IMM_B = 8'h95;
  localparam logic [7:0] CMD_INIT_GEOM = 8'h91;

  // set-feature option codes that govern soft-reset keep
  localparam logic [7:0] FEAT_REVERT_DEFAULTS = 8'hcc;
  localparam logic [7:0] FEAT_KEEP_SETTINGS = 8'h66;

  // timeout encoding bounds
  localparam logic [7:0] TMO_STEP_MAX = 8'hf0;     // 240
  localparam logic [7:0] TMO_HALF_HOUR_MAX = 8'hfb; // 251
  localparam logic [7:0] TMO_21MIN = 8'hfc;        // 252
  localparam logic [7:0] TMO_8HOUR = 8'hfd;        // 253
  localparam logic [7:0] TMO_ABORT = 8'hfe;        // 254
  localparam logic [7:0] TMO_21MIN15 = 8'hff;      // 255

  // timeout units in seconds
  localparam int unsigned TMO_STEP_SEC = 5;
  localparam int unsigned HALF_HOUR_SEC = 1800;
  localparam int unsigned SEC_21MIN = 1260;
  localparam int unsigned SEC_8HOUR = 28800;
  localparam int unsigned SEC_21MIN15 = 1275;

  // one-second tick from the 50 MHz clock
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned SEC_NS = 1000000000;
  localparam int unsigned CYC_PER_SEC = SEC_NS / (SEC_NS / CLK_HZ);

  // reset values
  localparam logic [7:0] SPT_RESET = 8'h00;
  localparam logic [3:0] HEADS_RESET = 4'h0;

  // error / status bit positions
  localparam int unsigned ERR_ABORT_BIT = 2;
  localparam int unsigned STS_ERR_BIT = 0;
  localparam int unsigned STS_DSC_BIT = 4;
  localparam int unsigned STS_RDY_BIT = 6;
  localparam int unsigned STS_BSY_BIT = 7;

  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_IDLE,
    PWR_STANDBY
  } ipg_pwr_t;

endpackage

// ### ipg_tick.sv
// one-cycle enable pulse once per divided period
// assumes clk and synchronous active-low rst_n
`timescale 1ns/1ns
module ipg_tick #(
  parameter int unsigned DIV = 50000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pulse out
  output logic tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } ipg_tick_st_t;

  ipg_tick_st_t s_q, s_d;

  // count down and pulse on wrap
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 32'h0) begin
      s_d.cnt = 32'(DIV - 1);
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt - 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

// ### ipg_cmd.sv
// idle / idle immediate / initialize geometry command interpreter
// assumes task-file values are on the same clock, valid with cmdValid
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Notes on behaviour
// - idle command enters idle, loads, starts timer
// - idle entry requests spin-up unless spinning
// - idle keeps spindle turning, commands accepted
// - zero timeout disables auto power-down
// - 1-240 times five; 241-251 half hours
// - 252,253,255 fixed intervals; 254 aborts
// - countdown expiry without access enters standby
// - host access reloads full interval
// - idle immediate enters idle, spins up
// - idle immediate keeps stored timer setting
// - geometry command stores sectors and head nibble
// - stored geometry reported for identify words
// - geometry kept until command, power, reverting reset
// - zero sectors per track means zero
// ---------------------------------------------------------------
module ipg_cmd #(
  parameter int unsigned SEC_DIV = ipg_pkg::CYC_PER_SEC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // task-file command strobe and fields
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] sectorCount,
  input wire logic [7:0] devHead,
  // any host access to the drive
  input wire logic hostAccess,
  // soft reset and currently selected reset option
  input wire logic softReset,
  input wire logic [7:0] resetFeature,
  // spindle feedback
  input wire logic spindleSpinning,
  // command completion
  output logic cmdDone,
  output logic [7:0] errorReg,
  output logic [7:0] statusReg,
  // power and spindle control
  output logic spinUpReq,
  output logic spinDownReq,
  output logic [1:0] powerState,
  output logic autoPdEnabled,
  // geometry for identify words 54-58
  output logic [7:0] sectorsPerTrack,
  output logic [3:0] headsMinusOne
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------

  // whole state of the interpreter in one register
  // interval and remain hold seconds; 15 bits cover the 8 hour setting
  typedef struct packed {
    ipg_pkg::ipg_pwr_t pwr;
    logic pdEn;
    logic [14:0] interval;
    logic [14:0] remain;
    logic [7:0] spt;
    logic [3:0] heads;
    logic done;
    logic [7:0] err;
    logic [7:0] sts;
    logic spinUp;
    logic spinDown;
  } ipg_st_t;

  ipg_st_t s_q, s_d;
  logic secTick;

  // -------------------------------------------------------------
  // second divider
  // -------------------------------------------------------------

  // one-second enable
  // the first tick after a load may come early, so an interval
  // can end up to one second short
  ipg_tick #(
    .DIV(SEC_DIV)
  ) uTick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(secTick)
  );

  // -------------------------------------------------------------
  // decoders
  // -------------------------------------------------------------

  // decode a timeout code into seconds
  // the reserved code falls through to zero; callers abort it first
  function automatic logic [14:0] tmoSeconds(input logic [7:0] v);
    logic [14:0] r;
    r = 15'h0;
    if (v <= ipg_pkg::TMO_STEP_MAX) begin
      r = 15'(v * ipg_pkg::TMO_STEP_SEC);
    end else if (v <= ipg_pkg::TMO_HALF_HOUR_MAX) begin
      r = 15'((v - ipg_pkg::TMO_STEP_MAX) * ipg_pkg::HALF_HOUR_SEC);
    end else if (v == ipg_pkg::TMO_21MIN) begin
      r = 15'(ipg_pkg::SEC_21MIN);
    end else if (v == ipg_pkg::TMO_8HOUR) begin
      r = 15'(ipg_pkg::SEC_8HOUR);
    end else if (v == ipg_pkg::TMO_21MIN15) begin
      r = 15'(ipg_pkg::SEC_21MIN15);
    end
    return r;
  endfunction

  // either opcode of the idle command
  function automatic logic isIdleCmd(input logic [7:0] c);
    return c == ipg_pkg::CMD_IDLE_A || c == ipg_pkg::CMD_IDLE_B;
  endfunction

  // either opcode of the idle immediate command
  function automatic logic isIdleImmCmd(input logic [7:0] c);
    return c == ipg_pkg::CMD_IDLE_IMM_A || c == ipg_pkg::CMD_IDLE_IMM_B;
  endfunction

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------

  // command handling, countdown and geometry
  // soft reset wins over a command in the same cycle, which is dropped
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.spinUp = 1'b0;
    s_d.spinDown = 1'b0;
    if (softReset) begin
      if (resetFeature == ipg_pkg::FEAT_REVERT_DEFAULTS) begin
        s_d.spt = ipg_pkg::SPT_RESET;
        s_d.heads = ipg_pkg::HEADS_RESET;
      end
    end else if (cmdValid) begin
      // accepted or not, every command completes with busy clear
      s_d.done = 1'b1;
      s_d.err = 8'h00;
      s_d.sts = 8'h00;
      s_d.sts[ipg_pkg::STS_RDY_BIT] = 1'b1; // busy clear, ready set
      s_d.sts[ipg_pkg::STS_DSC_BIT] = 1'b1;
      if (isIdleCmd(cmdCode)) begin
        // a reserved code leaves power state and timer untouched
        if (sectorCount == ipg_pkg::TMO_ABORT) begin
          s_d.err[ipg_pkg::ERR_ABORT_BIT] = 1'b1;
          s_d.sts[ipg_pkg::STS_ERR_BIT] = 1'b1;
        end else begin
          s_d.pwr = ipg_pkg::PWR_IDLE;
          s_d.spinUp = !spindleSpinning;
          s_d.pdEn = sectorCount != 8'h00;
          s_d.interval = tmoSeconds(sectorCount);
          s_d.remain = tmoSeconds(sectorCount);
        end
      end else if (isIdleImmCmd(cmdCode)) begin
        s_d.pwr = ipg_pkg::PWR_IDLE; // timer setting untouched
        s_d.spinUp = !spindleSpinning;
        s_d.remain = s_q.interval; // command is a host access
      end else if (cmdCode == ipg_pkg::CMD_INIT_GEOM) begin
        s_d.spt = sectorCount; // zero stored as zero
        s_d.heads = devHead[3:0];
        s_d.remain = s_q.interval;
      end else begin
        s_d.err[ipg_pkg::ERR_ABORT_BIT] = 1'b1;
        s_d.sts[ipg_pkg::STS_ERR_BIT] = 1'b1;
      end
    end
    // countdown, reload on any host access; aborted commands do not reload it
    // it only runs in idle; active and standby leave it frozen
    if (hostAccess) begin
      s_d.remain = s_d.interval;
    end else if (!cmdValid && !softReset) begin
      if (s_q.pdEn && s_q.pwr == ipg_pkg::PWR_IDLE && secTick) begin
        if (s_q.remain <= 15'h1) begin
          s_d.remain = 15'h0;
          s_d.pwr = ipg_pkg::PWR_STANDBY;
          s_d.spinDown = 1'b1;
        end else begin
          s_d.remain = s_q.remain - 15'h1;
        end
      end
    end
    // idle keeps the spindle turning if it stops
    // expiry in the same cycle takes priority and spins down instead
    if (s_q.pwr == ipg_pkg::PWR_IDLE && !spindleSpinning && !s_d.spinDown) begin
      s_d.spinUp = 1'b1;
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------

  // power-on reset clears geometry and timer and leaves the drive active
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------

  // outputs from the state register
  assign cmdDone = s_q.done;
  assign errorReg = s_q.err;
  assign statusReg = s_q.sts;
  assign spinUpReq = s_q.spinUp;
  assign spinDownReq = s_q.spinDown;
  assign powerState = s_q.pwr;
  assign autoPdEnabled = s_q.pdEn;
  assign sectorsPerTrack = s_q.spt;
  assign headsMinusOne = s_q.heads;

endmodule

// ### ipg_cmd_properties.sv
// checker: timing relations of the idle / geometry command interpreter
// assumes it is bound onto ipg_cmd and sees only its ports
`timescale 1ns/1ns
module ipg_cmd_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command side
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] sectorCount,
  input wire logic [7:0] devHead,
  input wire logic hostAccess,
  input wire logic softReset,
  input wire logic spindleSpinning,
  // results
  input wire logic cmdDone,
  input wire logic [7:0] errorReg,
  input wire logic [7:0] statusReg,
  input wire logic spinUpReq,
  input wire logic spinDownReq,
  input wire logic [1:0] powerState,
  input wire logic autoPdEnabled,
  input wire logic [7:0] sectorsPerTrack,
  input wire logic [3:0] headsMinusOne
);
  logic go, idl, imm, geo;
  // -------------------------------------------------------------
  // accepted command decode
  // -------------------------------------------------------------
  assign go = cmdValid && !softReset;
  assign idl = go && (cmdCode == 8'he3 || cmdCode == 8'h97);
  assign imm = go && (cmdCode == 8'he1 || cmdCode == 8'h95);
  assign geo = go && cmdCode == 8'h91;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_cmd_answer: assert property (go |=> cmdDone)
    else $error("no completion");
  chk_idle_enter: assert property (idl && sectorCount != 8'hfe |=> powerState == 2'h1 && statusReg == 8'h50)
    else $error("idle entry");
  chk_idle_zero: assert property (idl && sectorCount == 8'h00 |=> !autoPdEnabled)
    else $error("zero timeout armed");
  chk_idle_armed: assert property (idl && sectorCount != 8'h00 && sectorCount != 8'hfe |=> autoPdEnabled)
    else $error("timeout not armed");
  chk_reserved_abort: assert property (idl && sectorCount == 8'hfe |=> errorReg == 8'h04 && statusReg == 8'h51)
    else $error("reserved not aborted");
  chk_spin_up: assert property ((idl && sectorCount != 8'hfe || imm) && !spindleSpinning |=> spinUpReq)
    else $error("no spin up");
  chk_imm_keeps: assert property (imm |=> powerState == 2'h1 && autoPdEnabled == $past(autoPdEnabled))
    else $error("idle immediate");
  chk_geom_store: assert property (geo |=> sectorsPerTrack == $past(sectorCount) && headsMinusOne == $past(devHead[3:0]))
    else $error("geometry store");
  chk_geom_keep: assert property (!geo && !softReset |=> $stable(sectorsPerTrack) && $stable(headsMinusOne))
    else $error("geometry changed");
  chk_access_reload: assert property (hostAccess |=> !spinDownReq)
    else $error("expiry despite access");
  chk_expiry_standby: assert property (spinDownReq |-> powerState == 2'h2)
    else $error("expiry without standby");
  chk_idle_spin: assert property (powerState == 2'h1 && !spindleSpinning |=> spinUpReq || spinDownReq)
    else $error("idle spindle left stopped");
  chk_access_holdoff: assert property (hostAccess |=> !spinDownReq [*4])
    else $error("expiry soon after access");
endmodule

bind ipg_cmd ipg_cmd_properties i_props (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
  .cmdCode(cmdCode), .sectorCount(sectorCount), .devHead(devHead), .hostAccess(hostAccess),
  .softReset(softReset), .spindleSpinning(spindleSpinning), .cmdDone(cmdDone),
  .errorReg(errorReg), .statusReg(statusReg), .spinUpReq(spinUpReq), .spinDownReq(spinDownReq),
  .powerState(powerState), .autoPdEnabled(autoPdEnabled), .sectorsPerTrack(sectorsPerTrack),
  .headsMinusOne(headsMinusOne));

// ### ipg_host.sv
// host model: issues task-file commands one cycle wide
// assumes the interpreter's clock; fields change 1 ns after an edge
`timescale 1ns/1ns
module ipg_host (
  // clock
  input wire logic clk,
  // task-file fields
  output logic cmdValid,
  output logic [7:0] cmdCode,
  output logic [7:0] sectorCount,
  output logic [7:0] devHead
);
  // quiet bus at time zero
  initial begin
    cmdValid = 1'b0;
    cmdCode = 8'h00;
    sectorCount = 8'h00;
    devHead = 8'h00;
  end
  // one command; released fields are scrambled so stale values never look valid
  task automatic send(input logic [7:0] c, input logic [7:0] s, input logic [7:0] d);
    @(posedge clk);
    #1;
    cmdValid = 1'b1;
    cmdCode = c;
    sectorCount = s;
    devHead = {4'ha, d[3:0]};
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    cmdCode = ~c;
    sectorCount = ~s;
    devHead = ~devHead;
  endtask
endmodule

// ### tb_top.sv
// testbench for the idle / geometry command interpreter
// assumes ipg_host as command source and a short second divider
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, hostAccess = 1'b0, softReset = 1'b0, spindleSpinning = 1'b0;
  logic [7:0] resetFeature = 8'h66;
  logic cmdValid, cmdDone, spinUpReq, spinDownReq, autoPdEnabled;
  logic [7:0] cmdCode, sectorCount, devHead, errorReg, statusReg, sectorsPerTrack;
  logic [3:0] headsMinusOne;
  logic [1:0] powerState;
  logic [7:0] codes [7] = '{8'h05, 8'hf0, 8'hf1, 8'hfb, 8'hfc, 8'hfd, 8'hff};
  int err_count = 0, checks = 0, cyc = 0, n;
  initial forever #10 clk = ~clk;
  ipg_host i_host (.clk(clk), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .sectorCount(sectorCount), .devHead(devHead));
  ipg_cmd #(.SEC_DIV(4)) i_dut (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .sectorCount(sectorCount), .devHead(devHead), .hostAccess(hostAccess),
    .softReset(softReset), .resetFeature(resetFeature), .spindleSpinning(spindleSpinning),
    .cmdDone(cmdDone), .errorReg(errorReg), .statusReg(statusReg), .spinUpReq(spinUpReq),
    .spinDownReq(spinDownReq), .powerState(powerState), .autoPdEnabled(autoPdEnabled),
    .sectorsPerTrack(sectorsPerTrack), .headsMinusOne(headsMinusOne));
  // compare one value
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // closing report
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // wait for the countdown to expire, bounded
  task automatic wait_expiry(input int lim);
    for (n = 0; n < lim && spinDownReq !== 1'b1; n++) @(posedge clk) #1;
  endtask
  // soft reset pulse under a chosen option
  task automatic soft_reset(input logic [7:0] f);
    resetFeature = f;
    softReset = 1'b1;
    @(posedge clk) #1 softReset = 1'b0;
    @(posedge clk) #1;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // -------------------------------------------------------------
  // test sequence
  // -------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    i_host.send(8'he3, 8'h01, 8'h00);
    cmp(cmdDone, 8'h01, "no done");
    cmp(powerState, 8'h01, "not idle");
    cmp(statusReg, 8'h50, "idle status");
    cmp(spinUpReq, 8'h01, "no spin up");
    spindleSpinning = 1'b1;
    wait_expiry(60);
    cmp(n > 13 && n < 25, 8'h01, "interval");
    cmp(powerState, 8'h02, "no standby");
    $display("test timer done");
    i_host.send(8'h97, 8'hfe, 8'h00);
    cmp(errorReg, 8'h04, "reserved error");
    cmp(statusReg, 8'h51, "reserved status");
    cmp(powerState, 8'h02, "reserved changed state");
    i_host.send(8'h00, 8'h01, 8'h00);
    cmp(errorReg, 8'h04, "unknown code");
    cmp(statusReg, 8'h51, "unknown status");
    foreach (codes[i]) begin
      i_host.send(8'h97, codes[i], 8'h00);
      cmp(autoPdEnabled, 8'h01, "code not armed");
      cmp(errorReg, 8'h00, "code aborted");
    end
    i_host.send(8'he3, 8'hf1, 8'h00);
    wait_expiry(7300);
    cmp(n > 7190 && n < 7210, 8'h01, "half hour interval");
    i_host.send(8'he3, 8'hfc, 8'h00);
    wait_expiry(5100);
    cmp(n > 5030 && n < 5050, 8'h01, "21 minute interval");
    i_host.send(8'he3, 8'h00, 8'h00);
    cmp(autoPdEnabled, 8'h00, "zero armed");
    cmp(spinUpReq, 8'h00, "spin up while spinning");
    i_host.send(8'he1, 8'h00, 8'h00);
    cmp(powerState, 8'h01, "immediate idle");
    cmp(autoPdEnabled, 8'h00, "immediate armed");
    spindleSpinning = 1'b0;
    @(posedge clk) #1;
    cmp(spinUpReq, 8'h01, "idle let spindle stop");
    spindleSpinning = 1'b1;
    i_host.send(8'he3, 8'h01, 8'h00);
    hostAccess = 1'b1;
    repeat (40) @(posedge clk) #1;
    cmp(powerState, 8'h01, "standby despite access");
    hostAccess = 1'b0;
    wait_expiry(60);
    cmp(n > 13 && n < 25, 8'h01, "reload interval");
    cmp(powerState, 8'h02, "no standby after access");
    i_host.send(8'h95, 8'h00, 8'h00);
    cmp(autoPdEnabled, 8'h01, "immediate cleared timer");
    $display("test idle done");
    i_host.send(8'h91, 8'h00, 8'h0f);
    cmp(sectorsPerTrack, 8'h00, "zero sectors");
    cmp(headsMinusOne, 8'h0f, "heads");
    cmp(errorReg, 8'h00, "geometry aborted");
    i_host.send(8'h91, 8'h3f, 8'h05);
    soft_reset(8'h66);
    cmp(sectorsPerTrack, 8'h3f, "kept sectors");
    cmp(headsMinusOne, 8'h05, "kept heads");
    soft_reset(8'hcc);
    cmp(sectorsPerTrack, 8'h00, "reverted sectors");
    cmp(headsMinusOne, 8'h00, "reverted heads");
    i_host.send(8'h91, 8'h11, 8'h03);
    cmp(sectorsPerTrack, 8'h11, "sectors before power-off");
    rst_n = 1'b0;
    repeat (2) @(posedge clk) #1;
    rst_n = 1'b1;
    cmp(sectorsPerTrack, 8'h00, "power-off sectors");
    cmp(headsMinusOne, 8'h00, "power-off heads");
    $display("test geometry done");
    tally_and_finish();
  end
endmodule
